// [ldc_pkg.sv]
// constants and types shared by the led drive control design
package ldc_pkg;
    // ----------------------------------------------------------------
    // clock and timing
    // ----------------------------------------------------------------
    localparam int unsigned CLK_HZ          = 40_000_000;
    localparam int unsigned ON_DELAY_MS     = 100;
    localparam int unsigned ON_DELAY_CYCLES = (CLK_HZ / 1000) * ON_DELAY_MS;
    localparam int unsigned DLY_W           = 23;

    // ----------------------------------------------------------------
    // register offsets (byte addresses)
    // ----------------------------------------------------------------
    localparam logic [7:0] CTRL_OFS   = 8'h00;
    localparam logic [7:0] SLOT_OFS   = 8'h04;
    localparam logic [7:0] DUTY_R_OFS = 8'h08;
    localparam logic [7:0] DUTY_G_OFS = 8'h0c;
    localparam logic [7:0] DUTY_B_OFS = 8'h10;
    localparam logic [7:0] STAT_OFS   = 8'h14;

    // ----------------------------------------------------------------
    // control register fields
    // ----------------------------------------------------------------
    localparam int unsigned CTRL_SW_BIT  = 0;  // software led control on
    localparam int unsigned CTRL_SEQ_BIT = 1;  // display sequence runs
    localparam int unsigned CTRL_BUF_BIT = 2;  // colour enables passed to colour_en_out
    localparam int unsigned CTRL_EN_LSB  = 4;  // red, green, blue enables
    localparam int unsigned CTRL_W       = 7;

    // ----------------------------------------------------------------
    // status register fields
    // ----------------------------------------------------------------
    localparam int unsigned STAT_ON_BIT  = 0;
    localparam int unsigned STAT_SEL_LSB = 1;
    localparam int unsigned STAT_REQ_BIT = 3;
    localparam int unsigned STAT_PRK_BIT = 4;
    localparam int unsigned STAT_CFG_BIT = 5;

    // ----------------------------------------------------------------
    // reset values and widths
    // ----------------------------------------------------------------
    localparam logic [CTRL_W-1:0] CTRL_RST = 7'h00;
    localparam int unsigned       SLOT_W   = 16;
    localparam logic [15:0]       SLOT_RST = 16'h0fff;
    localparam int unsigned       DUTY_W   = 8;
    localparam logic [7:0]        DUTY_RST = 8'h80;

    // ----------------------------------------------------------------
    // colour select codes
    // ----------------------------------------------------------------
    localparam logic [1:0] SEL_NONE  = 2'h0;
    localparam logic [1:0] SEL_RED   = 2'h1;
    localparam logic [1:0] SEL_GREEN = 2'h2;
    localparam logic [1:0] SEL_BLUE  = 2'h3;

    // master enable states
    typedef enum logic [2:0] {
        LDC_OFF  = 3'h1,
        LDC_WAIT = 3'h2,
        LDC_ON   = 3'h4
    } ldc_state_e;
endpackage

// [ldc_pwm_if.sv]
// carrier between the led controller and its pwm generator
`timescale 1ns/10ps
interface ldc_pwm_if;
    import ldc_pkg::*;
    logic [2:0][DUTY_W-1:0] duty;      // index 0 red, 1 green, 2 blue
    logic [1:0]             sel;       // colour selected from the next cycle
    logic                   force_hi;  // hold all pwm lines high
    logic [2:0]             pwm;       // registered pwm lines

    modport ctrl (output duty, output sel, output force_hi, input pwm);
    modport gen  (input duty, input sel, input force_hi, output pwm);
endinterface // ldc_pwm_if

// [ldc_pwm_gen.sv]
// three-channel pwm generator for the led current lines
`timescale 1ns/10ps
module ldc_pwm_gen
    import ldc_pkg::*;
(
    input logic  pclk,
    input logic  presetn,
    ldc_pwm_if.gen bus
);
    logic [DUTY_W-1:0] cnt_reg;
    logic [DUTY_W-1:0] cnt_next;
    logic [2:0]        pwm_reg;
    logic [2:0]        pwm_next;

    // free running period counter
    always_comb begin
        cnt_next = cnt_reg + 8'h01;
    end

    // one channel per colour; select code of channel i is i+1
    genvar i;
    generate
        for (i = 0; i < 3; i++) begin : g_ch
            always_comb begin
                if (bus.force_hi) begin
                    pwm_next[i] = 1'b1;
                end else if (bus.sel == 2'(i + 1)) begin
                    pwm_next[i] = (cnt_reg < bus.duty[i]);
                end else begin
                    pwm_next[i] = 1'b0;
                end
            end
        end
    endgenerate

    // registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_reg <= 8'h00;
            pwm_reg <= 3'h7;
        end else begin
            cnt_reg <= cnt_next;
            pwm_reg <= pwm_next;
        end
    end

    assign bus.pwm = pwm_reg;
endmodule // ldc_pwm_gen

// [ldc_led_drive.sv]
// led drive control: master enable, colour sequencing, pwm and apb registers
`timescale 1ns/10ps
module ldc_led_drive
    import ldc_pkg::*;
#(
    parameter int unsigned ON_DELAY = ON_DELAY_CYCLES
)(
    input  logic        pclk,
    input  logic        presetn,
    input  logic        psel,
    input  logic        penable,
    input  logic        pwrite,
    input  logic [7:0]  paddr,
    input  logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic        pready,
    output logic        pslverr,
    input  logic        light_source_request,
    input  logic        park_n,
    input  logic        config_loaded,
    output logic        driver_master_on,
    output logic [1:0]  colour_select_code,
    output logic        red_current_pwm,
    output logic        green_current_pwm,
    output logic        blue_current_pwm,
    output logic [2:0]  colour_en_out,
    output logic [2:0]  colour_en_oe
);
    // ----------------------------------------------------------------
    // input synchronisers
    // ----------------------------------------------------------------
    logic [2:0] meta_reg;
    logic [2:0] sync_reg;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_reg <= 3'h0;
            sync_reg <= 3'h0;
        end else begin
            meta_reg <= {config_loaded, park_n, light_source_request};
            sync_reg <= meta_reg;
        end
    end
    logic req_s;
    logic park_s;
    logic cfg_s;
    assign req_s  = sync_reg[0];
    assign park_s = sync_reg[1];
    assign cfg_s  = sync_reg[2];

    // ----------------------------------------------------------------
    // apb register file
    // ----------------------------------------------------------------
    logic [CTRL_W-1:0]      ctrl_reg,  ctrl_next;
    logic [SLOT_W-1:0]      slot_reg,  slot_next;
    logic [2:0][DUTY_W-1:0] duty_reg,  duty_next;
    logic [31:0]            rdata_reg, rdata_next;
    logic                   rdy_reg,   rdy_next;
    logic                   err_reg,   err_next;
    ldc_state_e             st_reg,    st_next;
    logic [1:0]             sel_reg,   sel_next;

    // decode of a byte address, shared by read and write paths
    function automatic logic addr_hit(input logic [7:0] a);
        addr_hit = (a == CTRL_OFS) || (a == SLOT_OFS) || (a == DUTY_R_OFS) ||
                   (a == DUTY_G_OFS) || (a == DUTY_B_OFS) || (a == STAT_OFS);
    endfunction

    logic wr_go;
    assign wr_go = psel && penable && pready && pwrite && !pslverr;

    // register writes and read data, answered in the first access cycle
    always_comb begin
        ctrl_next  = ctrl_reg;
        slot_next  = slot_reg;
        duty_next  = duty_reg;
        rdata_next = rdata_reg;
        rdy_next   = psel && !penable;
        err_next   = psel && !penable && !addr_hit(paddr);
        if (wr_go) begin
            case (paddr)
                CTRL_OFS:   ctrl_next   = pwdata[CTRL_W-1:0];
                SLOT_OFS:   slot_next   = pwdata[SLOT_W-1:0];
                DUTY_R_OFS: duty_next[0] = pwdata[DUTY_W-1:0];
                DUTY_G_OFS: duty_next[1] = pwdata[DUTY_W-1:0];
                DUTY_B_OFS: duty_next[2] = pwdata[DUTY_W-1:0];
                default:    ctrl_next   = ctrl_reg;
            endcase
        end
        if (psel && !penable && !pwrite) begin
            rdata_next = 32'h0;
            case (paddr)
                CTRL_OFS:   rdata_next[CTRL_W-1:0] = ctrl_reg;
                SLOT_OFS:   rdata_next[SLOT_W-1:0] = slot_reg;
                DUTY_R_OFS: rdata_next[DUTY_W-1:0] = duty_reg[0];
                DUTY_G_OFS: rdata_next[DUTY_W-1:0] = duty_reg[1];
                DUTY_B_OFS: rdata_next[DUTY_W-1:0] = duty_reg[2];
                STAT_OFS: begin
                    rdata_next[STAT_ON_BIT]                = driver_master_on;
                    rdata_next[STAT_SEL_LSB+1:STAT_SEL_LSB] = colour_select_code;
                    rdata_next[STAT_REQ_BIT]               = req_s;
                    rdata_next[STAT_PRK_BIT]               = park_s;
                    rdata_next[STAT_CFG_BIT]               = cfg_s;
                end
                default:    rdata_next = 32'h0;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_reg  <= CTRL_RST;
            slot_reg  <= SLOT_RST;
            duty_reg  <= {DUTY_RST, DUTY_RST, DUTY_RST};
            rdata_reg <= 32'h0;
            rdy_reg   <= 1'b0;
            err_reg   <= 1'b0;
        end else begin
            ctrl_reg  <= ctrl_next;
            slot_reg  <= slot_next;
            duty_reg  <= duty_next;
            rdata_reg <= rdata_next;
            rdy_reg   <= rdy_next;
            err_reg   <= err_next;
        end
    end
    assign prdata  = rdata_reg;
    assign pready  = rdy_reg;
    assign pslverr = err_reg;

    // ----------------------------------------------------------------
    // master enable with power-on delay
    // ----------------------------------------------------------------
    logic [DLY_W-1:0] dly_reg, dly_next;
    logic             on_reg,  on_next;
    logic             both_up;
    assign both_up = req_s && park_s;

    always_comb begin
        st_next  = st_reg;
        dly_next = dly_reg;
        case (st_reg)
            LDC_OFF: begin
                dly_next = '0;
                if (both_up) begin
                    st_next = LDC_WAIT;
                end
            end
            LDC_WAIT: begin
                dly_next = dly_reg + 1'b1;
                if (!both_up) begin
                    st_next = LDC_OFF;
                end else if (dly_reg >= DLY_W'(ON_DELAY - 2)) begin
                    st_next = LDC_ON;
                end
            end
            LDC_ON: begin
                if (!both_up) begin
                    st_next = LDC_OFF;
                end
            end
            default: st_next = LDC_OFF;
        endcase
        on_next = (st_next == LDC_ON);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_reg  <= LDC_OFF;
            dly_reg <= '0;
            on_reg  <= 1'b0;
        end else begin
            st_reg  <= st_next;
            dly_reg <= dly_next;
            on_reg  <= on_next;
        end
    end
    assign driver_master_on = on_reg;

    // ----------------------------------------------------------------
    // display sequence: red, green, blue slots
    // ----------------------------------------------------------------
    logic [SLOT_W-1:0] slot_cnt_reg, slot_cnt_next;
    logic              seq_run;
    assign seq_run = ctrl_reg[CTRL_SEQ_BIT];

    always_comb begin
        sel_next      = sel_reg;
        slot_cnt_next = slot_cnt_reg + 1'b1;
        if (!on_next || !seq_run) begin
            sel_next      = SEL_NONE;
            slot_cnt_next = '0;
        end else if (sel_reg == SEL_NONE) begin
            sel_next      = SEL_RED;
            slot_cnt_next = '0;
        end else if (slot_cnt_reg >= slot_reg) begin
            slot_cnt_next = '0;
            case (sel_reg)
                SEL_RED:   sel_next = SEL_GREEN;
                SEL_GREEN: sel_next = SEL_BLUE;
                SEL_BLUE:  sel_next = SEL_RED;
                default:   sel_next = SEL_NONE;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sel_reg      <= SEL_NONE;
            slot_cnt_reg <= '0;
        end else begin
            sel_reg      <= sel_next;
            slot_cnt_reg <= slot_cnt_next;
        end
    end
    assign colour_select_code = sel_reg;

    // ----------------------------------------------------------------
    // pwm generator
    // ----------------------------------------------------------------
    ldc_pwm_if pwm_bus ();
    assign pwm_bus.duty = duty_reg;
    assign pwm_bus.sel  = sel_next;
    assign pwm_bus.force_hi = !on_next || !ctrl_reg[CTRL_SW_BIT] || !seq_run;

    ldc_pwm_gen u_pwm (
        .pclk    (pclk),
        .presetn (presetn),
        .bus     (pwm_bus.gen)
    );
    assign red_current_pwm   = pwm_bus.pwm[0];
    assign green_current_pwm = pwm_bus.pwm[1];
    assign blue_current_pwm  = pwm_bus.pwm[2];

    // ----------------------------------------------------------------
    // colour enable pins
    // ----------------------------------------------------------------
    logic [2:0] en_out_reg, en_out_next;
    logic [2:0] en_oe_reg,  en_oe_next;
    always_comb begin
        en_oe_next  = {3{cfg_s}};
        en_out_next = 3'h0;
        if (cfg_s && ctrl_reg[CTRL_BUF_BIT]) begin
            en_out_next = ctrl_reg[CTRL_EN_LSB+2:CTRL_EN_LSB];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            en_out_reg <= 3'h0;
            en_oe_reg  <= 3'h0;
        end else begin
            en_out_reg <= en_out_next;
            en_oe_reg  <= en_oe_next;
        end
    end
    assign colour_en_out = en_out_reg;
    assign colour_en_oe  = en_oe_reg;
endmodule // ldc_led_drive

// [ldc_led_drive_properties.sv]
// concurrent checks on the led drive control top-level ports
`timescale 1ns/10ps
module ldc_led_drive_properties
    import ldc_pkg::*;
#(
    parameter int unsigned ON_DELAY = 20
)(
    input logic       pclk,
    input logic       presetn,
    input logic       psel,
    input logic       penable,
    input logic       pready,
    input logic       pslverr,
    input logic       light_source_request,
    input logic       park_n,
    input logic       config_loaded,
    input logic       driver_master_on,
    input logic [1:0] colour_select_code,
    input logic       red_current_pwm,
    input logic       green_current_pwm,
    input logic       blue_current_pwm,
    input logic [2:0] colour_en_out,
    input logic [2:0] colour_en_oe
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    logic [31:0] on_cnt_reg;
    logic [31:0] on_cnt_next;
    logic [2:0]  pwm;

    // cycles for which request and park pins have both been high
    always_comb begin
        on_cnt_next = (light_source_request && park_n) ? on_cnt_reg + 32'h1 : 32'h0;
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) on_cnt_reg <= 32'h0;
        else on_cnt_reg <= on_cnt_next;
    end
    assign pwm = {blue_current_pwm, green_current_pwm, red_current_pwm};

    a_on_not_early: assert property ($rose(driver_master_on) |-> on_cnt_reg >= ON_DELAY)
        else $error("master enable rose before the on delay");
    a_on_not_late: assert property (on_cnt_reg == ON_DELAY + 8 |-> driver_master_on)
        else $error("master enable late after request");
    a_master_drop: assert property ((!light_source_request || !park_n) [*3] |=> !driver_master_on)
        else $error("master enable did not drop");
    a_sel_forced_none: assert property (!driver_master_on |-> colour_select_code == SEL_NONE)
        else $error("select code not none while master off");
    a_pwm_idle_high: assert property (colour_select_code == SEL_NONE |-> pwm == 3'h7)
        else $error("pwm lines not forced high");
    a_pwm_only_selected: assert property (colour_select_code != SEL_NONE |->
        (pwm == 3'h7) || ((pwm & ~(3'h1 << (colour_select_code - 2'h1))) == 3'h0))
        else $error("pwm active on a colour not selected");
    a_enables_idle_low: assert property (!config_loaded [*4] |=> colour_en_out == 3'h0 && colour_en_oe == 3'h0)
        else $error("colour enables active before configuration");
    a_enables_driven: assert property (config_loaded [*4] |=> colour_en_oe == 3'h7)
        else $error("colour enables not driven after configuration");
    a_apb_one_wait: assert property (psel && !penable |=> pready ##1 !pready)
        else $error("pready not a single pulse after setup");
    a_err_with_ready: assert property (pslverr |-> pready && psel && penable)
        else $error("pslverr outside an access cycle");
endmodule // ldc_led_drive_properties

// [ldc_led_model.sv]
// external led driver with select decoder
`timescale 1ns/10ps
module ldc_led_model
    import ldc_pkg::*;
(
    input  logic       driver_master_on,
    input  logic [1:0] colour_select_code,
    input  logic [2:0] colour_en_out,
    output logic [2:0] lit
);
    always_comb begin
        lit = 3'h0;
        if (driver_master_on && colour_select_code != SEL_NONE) lit = 3'h1 << (colour_select_code - 2'h1);
        lit = lit & colour_en_out;
    end
endmodule // ldc_led_model

// [led_drive_control_tb_top.sv]
// self-checking bench for the led drive control block
`timescale 1ns/10ps
`define CHK(n, e, g) begin \
    check_count++; \
    if ((g) !== (e)) begin \
        err_total++; \
        $display("wrong value %s exp %h got %h", n, e, g); \
    end \
end
module led_drive_control_tb_top;
    import ldc_pkg::*;
    localparam int unsigned OND = 20;
    logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, q;
    logic        pready, pslverr, e, light_source_request = 1'b0, park_n = 1'b1, config_loaded = 1'b0;
    logic        driver_master_on, red_current_pwm, green_current_pwm, blue_current_pwm;
    logic [1:0]  colour_select_code;
    logic [2:0]  colour_en_out, colour_en_oe, lit, pwm;
    int          err_total = 0, check_count = 0, n;

    always #12.5 pclk = ~pclk;
    assign pwm = {blue_current_pwm, green_current_pwm, red_current_pwm};

    ldc_led_drive #(.ON_DELAY(OND)) i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .light_source_request(light_source_request), .park_n(park_n), .config_loaded(config_loaded),
        .driver_master_on(driver_master_on), .colour_select_code(colour_select_code),
        .red_current_pwm(red_current_pwm), .green_current_pwm(green_current_pwm),
        .blue_current_pwm(blue_current_pwm), .colour_en_out(colour_en_out), .colour_en_oe(colour_en_oe));
    ldc_led_model i_led (.driver_master_on(driver_master_on), .colour_select_code(colour_select_code),
        .colour_en_out(colour_en_out), .lit(lit));

    task automatic end_sim();
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    // one apb transfer, held until pready is seen
    task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
        int k;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (k = 0; k < 20; k++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        if (k == 20) begin
            err_total++;
            end_sim();
        end
        q = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    // cycles until the master enable reaches v
    task automatic wait_on(input logic v);
        for (n = 1; n < OND + 40; n++) begin
            @(posedge pclk);
            #1;
            if (driver_master_on === v) break;
        end
        // a wait that runs out is a failure and ends the run
        if (n == OND + 40) begin
            err_total++;
            end_sim();
        end
    endtask

    task automatic t_regs();
        apb(CTRL_OFS, 1'b0, 32'h0); `CHK("ctrl rst", 32'h0, q)
        apb(SLOT_OFS, 1'b0, 32'h0); `CHK("slot rst", 32'h0fff, q)
        for (int i = 0; i < 3; i++) begin
            apb(DUTY_R_OFS + 8'(4 * i), 1'b0, 32'h0); `CHK("duty rst", 32'h80, q)
        end
        apb(8'h18, 1'b0, 32'h0); `CHK("unmapped err", 1'b1, e) `CHK("unmapped data", 32'h0, q)
        apb(STAT_OFS, 1'b1, 32'hffffffff); `CHK("status write err", 1'b0, e)
        $display("test regs done");
    endtask

    task automatic t_enables();
        config_loaded <= 1'b1;
        repeat (5) @(posedge pclk);
        #1 `CHK("en oe", 3'h7, colour_en_oe)
        `CHK("en idle", 3'h0, colour_en_out)
        apb(CTRL_OFS, 1'b1, 32'h70); repeat (2) @(posedge pclk);
        #1 `CHK("en no buf", 3'h0, colour_en_out)
        apb(CTRL_OFS, 1'b1, 32'h57); repeat (2) @(posedge pclk);
        #1 `CHK("en red blue", 3'h5, colour_en_out)
        $display("test enables done");
    endtask

    task automatic t_power_on();
        logic [1:0] seq [3];
        seq = '{SEL_GREEN, SEL_BLUE, SEL_RED};
        apb(CTRL_OFS, 1'b1, 32'h77);
        apb(SLOT_OFS, 1'b1, 32'h3);
        apb(DUTY_G_OFS, 1'b1, 32'h0);
        @(posedge pclk);
        light_source_request <= 1'b1;
        wait_on(1'b1);
        `CHK("on delay", 1'b1, n >= OND && n <= OND + 6)
        `CHK("first sel", SEL_RED, colour_select_code)
        for (int k = 0; k < 3; k++) begin
            for (n = 0; n < 20 && colour_select_code === seq[(k + 2) % 3]; n++) begin
                @(posedge pclk); #1;
            end
            `CHK("slot length", 4, n)
            if (n == 20) end_sim();
            `CHK("sel order", seq[k], colour_select_code)
            `CHK("decoded", 3'h1 << (seq[k] - 2'h1), lit)
            if (seq[k] == SEL_GREEN) `CHK("zero duty", 3'h0, pwm)
        end
        apb(CTRL_OFS, 1'b1, 32'h76); repeat (2) @(posedge pclk);
        #1 `CHK("sw off pwm", 3'h7, pwm)
        // stopping the sequence alone must force the lines and the code
        apb(CTRL_OFS, 1'b1, 32'h75);
        repeat (2) @(posedge pclk);
        #1 `CHK("seq stop pwm", 3'h7, pwm)
        `CHK("seq stop sel", SEL_NONE, colour_select_code)
        // restore full control so the park test sees forcing by master only
        apb(CTRL_OFS, 1'b1, 32'h77);
        apb(STAT_OFS, 1'b0, 32'h0);
        `CHK("status on", 1'b1, q[STAT_ON_BIT])
        $display("test power on done");
    endtask

    task automatic t_park();
        park_n <= 1'b0;
        wait_on(1'b0);
        `CHK("park drop", 1'b1, n <= 4)
        `CHK("park sel", SEL_NONE, colour_select_code)
        `CHK("park pwm", 3'h7, pwm)
        @(posedge pclk);
        light_source_request <= 1'b0;
        park_n <= 1'b1;
        repeat (OND / 2) @(posedge pclk);
        light_source_request <= 1'b1;
        repeat (OND / 2) @(posedge pclk);
        light_source_request <= 1'b0;
        repeat (OND + 10) @(posedge pclk);
        #1 `CHK("short pulse", 1'b0, driver_master_on)
        @(posedge pclk);
        light_source_request <= 1'b1;
        wait_on(1'b1);
        `CHK("restart delay", 1'b1, n >= OND && n <= OND + 6)
        @(posedge pclk);
        light_source_request <= 1'b0;
        wait_on(1'b0);
        `CHK("request drop", 1'b1, n <= 4)
        `CHK("request sel", SEL_NONE, colour_select_code)
        $display("test park done");
    endtask

    initial begin
        repeat (3) @(posedge pclk);
        #1 `CHK("rst master", 1'b0, driver_master_on)
        `CHK("rst pwm", 3'h7, pwm)
        `CHK("rst en", 3'h0, colour_en_oe)
        presetn <= 1'b1;
        t_regs();
        t_enables();
        t_power_on();
        t_park();
        end_sim();
    end
endmodule // led_drive_control_tb_top

bind ldc_led_drive ldc_led_drive_properties #(.ON_DELAY(ON_DELAY)) i_props (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr),
    .light_source_request(light_source_request), .park_n(park_n), .config_loaded(config_loaded),
    .driver_master_on(driver_master_on), .colour_select_code(colour_select_code),
    .red_current_pwm(red_current_pwm), .green_current_pwm(green_current_pwm),
    .blue_current_pwm(blue_current_pwm), .colour_en_out(colour_en_out), .colour_en_oe(colour_en_oe));
